// File: four_level_vectored_irq_ctrl_test.sv
// Self-checking bench for the vectored interrupt controller
`timescale 1ns/10ps
`default_nettype none
module four_level_vectored_irq_ctrl_test
  import fvic_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic core_clk = 1'b0, rst_n = 1'b0, global_irq_enable = 1'b0;
  logic [13:0] slot_enable = 14'h0, priority_high_bit = 14'h0, priority_low_bit = 14'h0;
  logic ext0_pin = 1'b0, ext1_pin = 1'b0, ext0_trigger_type = 1'b1, ext1_trigger_type = 1'b1;
  logic [3:0] flag_sw_set = 4'h0, flag_sw_clr = 4'h0, adc_flags = 4'h0;
  logic timer0_rollover = 1'b0, timer1_rollover = 1'b0;
  logic uart_receive_flag = 1'b0, uart_transmit_flag = 1'b0, spi_done_flag = 1'b0;
  logic timer2_overflow_flag = 1'b0, timer2_external_flag = 1'b0;
  logic timer2_low_byte_overflow_flag = 1'b0, pca_counter_overflow_flag = 1'b0;
  logic [3:0] pca_module_match_flags = 4'h0;
  logic [8:0] system_flags = 9'h0;
  logic uart_tx_sysflag_route = 1'b0, keypad_match_flag = 1'b0, twi_state_flag = 1'b0;
  logic comparator_change_flag = 1'b0, vector_ack, service_return, vector_req;
  logic [15:0] vector_addr;
  logic [3:0] vector_slot;
  logic ext0_request_flag, ext1_request_flag, timer0_overflow_flag, timer1_overflow_flag;
  logic [2:0] active_level;
  logic [1:0] ack_delay = 2'h0;
  logic ret_cmd = 1'b0;
  logic [31:0] seed = 32'd11;
  int bad_count = 0, n_compared = 0;

  // 25 ns period
  always #12.5 core_clk = ~core_clk;

  fvic_ctrl i_dut (.core_clk(core_clk), .rst_n(rst_n), .global_irq_enable(global_irq_enable),
    .slot_enable(slot_enable), .priority_high_bit(priority_high_bit),
    .priority_low_bit(priority_low_bit), .ext0_pin(ext0_pin), .ext1_pin(ext1_pin),
    .ext0_trigger_type(ext0_trigger_type), .ext1_trigger_type(ext1_trigger_type),
    .flag_sw_set(flag_sw_set), .flag_sw_clr(flag_sw_clr), .timer0_rollover(timer0_rollover),
    .timer1_rollover(timer1_rollover), .uart_receive_flag(uart_receive_flag),
    .uart_transmit_flag(uart_transmit_flag), .timer2_overflow_flag(timer2_overflow_flag),
    .timer2_external_flag(timer2_external_flag),
    .timer2_low_byte_overflow_flag(timer2_low_byte_overflow_flag),
    .spi_done_flag(spi_done_flag), .adc_flags(adc_flags[2:0]),
    .pca_counter_overflow_flag(pca_counter_overflow_flag),
    .pca_module_match_flags(pca_module_match_flags), .system_flags(system_flags),
    .uart_tx_sysflag_route(uart_tx_sysflag_route), .keypad_match_flag(keypad_match_flag),
    .twi_state_flag(twi_state_flag), .comparator_change_flag(comparator_change_flag),
    .vector_ack(vector_ack), .service_return(service_return), .vector_req(vector_req),
    .vector_addr(vector_addr), .vector_slot(vector_slot),
    .ext0_request_flag(ext0_request_flag), .ext1_request_flag(ext1_request_flag),
    .timer0_overflow_flag(timer0_overflow_flag), .timer1_overflow_flag(timer1_overflow_flag),
    .active_level(active_level));

  fvic_core_model i_core (.core_clk(core_clk), .rst_n(rst_n), .vector_req(vector_req),
    .ack_delay(ack_delay), .ret_cmd(ret_cmd), .vector_ack(vector_ack),
    .service_return(service_return));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  // Winner: highest code, lowest slot on a tie; bit 4 set when none
  function automatic logic [4:0] pick(input logic [13:0] rq, input logic [13:0] h, l);
    logic [4:0] w;
    logic [2:0] best;
    w = 5'h10;
    best = 3'h0;
    for (int s = 0; s < 14; s++) begin
      if (s != 6 && rq[s] && {1'b1, h[s], l[s]} > best) begin
        best = {1'b1, h[s], l[s]};
        w = {1'b0, 4'(s)};
      end
    end
    return w;
  endfunction : pick

  // Flags {ext0, ext1, tmr0, tmr1} left after a call; only the vectored one clears
  function automatic logic [3:0] flags_after(input logic [13:0] m, input logic [4:0] w);
    logic [3:0] f;
    f = {m[0], m[2], m[1], m[3]};
    case (w)
      5'h00: f[3] = 1'b0;
      5'h01: f[1] = 1'b0;
      5'h02: f[2] = 1'b0;
      5'h03: f[0] = 1'b0;
      default: ;
    endcase
    return f;
  endfunction : flags_after

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic tick(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : tick

  task automatic no_call(input int n);
    repeat (n) begin
      tick(1);
      chk(16'(vector_req), 16'h0);
    end
  endtask : no_call

  // Wait for a call, check its vector, let the model take it
  task automatic take_call(input int s);
    int i;
    i = 0;
    while (vector_req !== 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    chk(16'(vector_req), 16'h1);
    chk(vector_addr, VEC_BASE + VEC_STEP * 16'(s));
    chk(16'(vector_slot), 16'(s));
    i = 0;
    while (vector_req === 1'b1 && i < 40) begin
      tick(1);
      i++;
    end
    chk(16'(vector_req), 16'h0);
  endtask : take_call

  task automatic end_routine();
    @(posedge core_clk);
    ret_cmd <= 1'b1;
    @(posedge core_clk);
    ret_cmd <= 1'b0;
    tick(3);
  endtask : end_routine

  // Raise sources of mask m through one random sub-flag each
  task automatic set_src(input logic [13:0] m, output logic [13:0] em);
    logic [31:0] r;
    r = rnd();
    @(posedge core_clk);
    flag_sw_set <= {m[3], m[1], m[2], m[0]};
    uart_receive_flag <= m[4] & r[0];
    uart_transmit_flag <= m[4] & ~r[0];
    timer2_overflow_flag <= m[5] & (r[2:1] == 2'h0);
    timer2_external_flag <= m[5] & (r[2:1] == 2'h1);
    timer2_low_byte_overflow_flag <= m[5] & r[2];
    spi_done_flag <= m[7];
    adc_flags <= m[8] ? 4'h1 << (r[4:3] % 3) : 4'h0;
    pca_counter_overflow_flag <= m[9] & r[5];
    pca_module_match_flags <= (m[9] && !r[5]) ? 4'h1 << r[7:6] : 4'h0;
    system_flags <= m[10] ? 9'h1 << (r[11:8] % 9) : 9'h0;
    uart_tx_sysflag_route <= r[12];
    keypad_match_flag <= m[11];
    twi_state_flag <= m[12];
    comparator_change_flag <= m[13];
    em = m | {3'h0, r[12] & m[4] & ~r[0], 10'h0};
    @(posedge core_clk);
    flag_sw_set <= 4'h0;
  endtask : set_src

  task automatic stop_test();
    if (bad_count == 0 && n_compared > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : stop_test

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [13:0] m, em, h, l, e;
    logic [4:0] w;
    repeat (6) @(posedge core_clk);
    #1;
    chk({vector_addr[11:0], active_level, vector_req}, 16'h0030);
    rst_n <= 1'b1;
    // External pins: ext0 level, ext1 edge
    @(posedge core_clk);
    ext0_trigger_type <= 1'b0;
    slot_enable <= 14'h3fbf;
    global_irq_enable <= 1'b1;
    ext0_pin <= 1'b1;
    take_call(0);
    chk(16'(ext0_request_flag), 16'h1);
    @(posedge core_clk);
    ext0_pin <= 1'b0;
    tick(5);
    chk(16'(ext0_request_flag), 16'h0);
    end_routine();
    @(posedge core_clk);
    ext1_pin <= 1'b1;
    take_call(2);
    chk(16'(ext1_request_flag), 16'h0);
    ext1_pin <= 1'b0;
    end_routine();
    // Nesting: equal level blocked, higher level preempts
    priority_low_bit <= 14'h0880;
    priority_high_bit <= 14'h2000;
    spi_done_flag <= 1'b1;
    take_call(7);
    chk(16'(active_level), 16'h2);
    @(posedge core_clk);
    keypad_match_flag <= 1'b1;
    no_call(10);
    comparator_change_flag <= 1'b1;
    take_call(13);
    chk(16'(active_level), 16'h3);
    comparator_change_flag <= 1'b0;
    end_routine();
    chk(16'(active_level), 16'h2);
    spi_done_flag <= 1'b0;
    end_routine();
    take_call(11);
    keypad_match_flag <= 1'b0;
    end_routine();
    @(posedge core_clk);
    timer1_rollover <= 1'b1;
    @(posedge core_clk);
    timer1_rollover <= 1'b0;
    take_call(3);
    chk(16'(timer1_overflow_flag), 16'h0);
    end_routine();
    // Random mixes of sources, enables and levels
    for (int it = 0; it < 60; it++) begin
      @(posedge core_clk);
      global_irq_enable <= 1'b0;
      ext0_trigger_type <= 1'b1;
      h = 14'(rnd());
      l = (it % 4 == 0) ? h : 14'(rnd());
      m = 14'(rnd()) & 14'h3fbf;
      // An empty mix would leave nothing to call
      if (m == 14'h0) m = 14'h0080;
      e = 14'(rnd()) | m;
      slot_enable <= e;
      priority_high_bit <= h;
      priority_low_bit <= l;
      ack_delay <= 2'(rnd());
      set_src(m, em);
      no_call(4);
      global_irq_enable <= 1'b1;
      w = pick(em & e, h, l);
      take_call(int'(w[3:0]));
      chk(16'(active_level), 16'({h[w[3:0]], l[w[3:0]]}) + 16'h1);
      chk(16'({ext0_request_flag, ext1_request_flag, timer0_overflow_flag,
        timer1_overflow_flag}), 16'(flags_after(m, w)));
      @(posedge core_clk);
      global_irq_enable <= 1'b0;
      flag_sw_clr <= 4'hf;
      set_src(14'h0, em);
      flag_sw_clr <= 4'h0;
      tick(1);
      chk(16'({ext0_request_flag, ext1_request_flag, timer0_overflow_flag,
        timer1_overflow_flag}), 16'h0);
      end_routine();
      chk(16'(active_level), 16'h0);
    end
    stop_test();
  end

  // Watchdog well beyond the expected run length
  initial begin
    #500000;
    bad_count++;
    stop_test();
  end
endmodule : four_level_vectored_irq_ctrl_test
`default_nettype wire

// File: fvic_core_model.sv
// Core-side partner model: takes vector calls and ends service routines
`timescale 1ns/10ps
`default_nettype none
module fvic_core_model
  import fvic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic vector_req,
  input wire logic [1:0] ack_delay,
  input wire logic ret_cmd,
  output logic vector_ack,
  output logic service_return
);
  // ----------------------------------------------------------------
  // Call acceptance
  // ----------------------------------------------------------------
  logic [1:0] wait_ff;
  // One ack per call after a chosen stall, so slow cores are exercised too
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wait_ff <= 2'h0;
      vector_ack <= 1'b0;
    end else if (vector_ack || !vector_req) begin
      wait_ff <= 2'h0;
      vector_ack <= 1'b0;
    end else if (wait_ff == ack_delay) begin
      vector_ack <= 1'b1;
    end else begin
      wait_ff <= wait_ff + 2'h1;
    end
  end
  // Routine end is a one-cycle pulse on command of the bench
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      service_return <= 1'b0;
    end else begin
      service_return <= ret_cmd;
    end
  end
endmodule : fvic_core_model
`default_nettype wire

// File: fvic_ctrl.sv
// Four-level vectored interrupt controller top
`timescale 1ns/10ps
`default_nettype none
module fvic_ctrl
  import fvic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  // Global and per-slot controls
  input wire logic global_irq_enable,
  input wire logic [NUM_SLOTS-1:0] slot_enable,
  input wire logic [NUM_SLOTS-1:0] priority_high_bit,
  input wire logic [NUM_SLOTS-1:0] priority_low_bit,
  // External interrupt pins, already polarity-adjusted, active high
  input wire logic ext0_pin,
  input wire logic ext1_pin,
  input wire logic ext0_trigger_type,
  input wire logic ext1_trigger_type,
  // Software writes to the flags owned here
  input wire logic [3:0] flag_sw_set,
  input wire logic [3:0] flag_sw_clr,
  // Timer rollover events, same clock
  input wire logic timer0_rollover,
  input wire logic timer1_rollover,
  // Peripheral flags held in their own blocks
  input wire logic uart_receive_flag,
  input wire logic uart_transmit_flag,
  input wire logic timer2_overflow_flag,
  input wire logic timer2_external_flag,
  input wire logic timer2_low_byte_overflow_flag,
  input wire logic spi_done_flag,
  input wire logic [ADC_W-1:0] adc_flags,
  input wire logic pca_counter_overflow_flag,
  input wire logic [PCA_MOD_W-1:0] pca_module_match_flags,
  input wire logic [SYS_W-1:0] system_flags,
  input wire logic uart_tx_sysflag_route,
  input wire logic keypad_match_flag,
  input wire logic twi_state_flag,
  input wire logic comparator_change_flag,
  // Core handshake
  input wire logic vector_ack,
  input wire logic service_return,
  output logic vector_req,
  output logic [15:0] vector_addr,
  output logic [SLOT_W-1:0] vector_slot,
  // Flag state visible to software
  output logic ext0_request_flag,
  output logic ext1_request_flag,
  output logic timer0_overflow_flag,
  output logic timer1_overflow_flag,
  output logic [2:0] active_level
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Vector of a slot: base plus eight bytes per slot
  function automatic logic [15:0] slot_vector(input logic [SLOT_W-1:0] s);
    slot_vector = VEC_BASE + VEC_STEP * {12'h000, s};
  endfunction : slot_vector

  // Priority code to level 1..4, 4 being highest
  function automatic logic [2:0] code_level(input logic [1:0] c);
    code_level = {1'b0, c} + 3'h1;
  endfunction : code_level

  // ----------------------------------------------------------------
  // Flags held here: external and timer 0/1
  // ----------------------------------------------------------------
  logic ack_ext0;
  logic ack_ext1;
  logic ack_t0;
  logic ack_t1;
  logic tf0_ff;
  logic tf1_ff;
  logic nxt_tf0;
  logic nxt_tf1;
  logic call_take;
  logic [SLOT_W-1:0] slot_ff;

  assign call_take = vector_req & vector_ack;
  assign ack_ext0 = call_take && (slot_ff == SLOT_EXT0);
  assign ack_ext1 = call_take && (slot_ff == SLOT_EXT1);
  assign ack_t0 = call_take && (slot_ff == SLOT_TMR0);
  assign ack_t1 = call_take && (slot_ff == SLOT_TMR1);

  fvic_ext_flag u_ext0 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_active(ext0_pin),
    .trigger_type(ext0_trigger_type),
    .sw_set(flag_sw_set[0]),
    .sw_clr(flag_sw_clr[0]),
    .vector_ack(ack_ext0),
    .flag(ext0_request_flag)
  );

  fvic_ext_flag u_ext1 (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .pin_active(ext1_pin),
    .trigger_type(ext1_trigger_type),
    .sw_set(flag_sw_set[1]),
    .sw_clr(flag_sw_clr[1]),
    .vector_ack(ack_ext1),
    .flag(ext1_request_flag)
  );

  // Timer flags: rollover or software set beats any clear
  always_comb begin
    nxt_tf0 = tf0_ff;
    nxt_tf1 = tf1_ff;
    if (ack_t0 || flag_sw_clr[2]) nxt_tf0 = 1'b0;
    if (ack_t1 || flag_sw_clr[3]) nxt_tf1 = 1'b0;
    if (timer0_rollover || flag_sw_set[2]) nxt_tf0 = 1'b1;
    if (timer1_rollover || flag_sw_set[3]) nxt_tf1 = 1'b1;
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tf0_ff <= 1'b0;
      tf1_ff <= 1'b0;
    end else begin
      tf0_ff <= nxt_tf0;
      tf1_ff <= nxt_tf1;
    end
  end
  assign timer0_overflow_flag = tf0_ff;
  assign timer1_overflow_flag = tf1_ff;

  // ----------------------------------------------------------------
  // Request gathering per slot
  // ----------------------------------------------------------------
  // Peripheral flags stay in their blocks, so nothing here clears them
  logic [NUM_SLOTS-1:0] raw_req;
  logic sys_req;
  assign sys_req = (|system_flags) | (uart_tx_sysflag_route & uart_transmit_flag);
  assign raw_req[0] = ext0_request_flag;
  assign raw_req[1] = tf0_ff;
  assign raw_req[2] = ext1_request_flag;
  assign raw_req[3] = tf1_ff;
  assign raw_req[4] = uart_receive_flag | uart_transmit_flag;
  assign raw_req[5] = timer2_overflow_flag | timer2_external_flag
                    | timer2_low_byte_overflow_flag;
  assign raw_req[6] = 1'b0;
  assign raw_req[7] = spi_done_flag;
  assign raw_req[8] = |adc_flags;
  assign raw_req[9] = pca_counter_overflow_flag | (|pca_module_match_flags);
  assign raw_req[10] = sys_req;
  assign raw_req[11] = keypad_match_flag;
  assign raw_req[12] = twi_state_flag;
  assign raw_req[13] = comparator_change_flag;

  // Sample stage: one clock of registration before polling
  logic [NUM_SLOTS-1:0] sample_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) sample_ff <= '0;
    else sample_ff <= raw_req & slot_enable & {NUM_SLOTS{global_irq_enable}};
  end

  // ----------------------------------------------------------------
  // Arbitration: highest level, then lowest slot
  // ----------------------------------------------------------------
  logic [2:0] best_lvl;
  logic [SLOT_W-1:0] best_slot;
  logic best_found;
  logic [2:0] cur_lvl;
  always_comb begin
    best_lvl = LVL_NONE;
    best_slot = '0;
    best_found = 1'b0;
    cur_lvl = LVL_NONE;
    // Descending loop with >= leaves the lowest slot on ties
    for (int i = NUM_SLOTS - 1; i >= 0; i--) begin
      cur_lvl = code_level({priority_high_bit[i], priority_low_bit[i]});
      if (sample_ff[i] && cur_lvl >= best_lvl) begin
        best_lvl = cur_lvl;
        best_slot = SLOT_W'(i);
        best_found = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // In-progress levels: one nesting bit per level
  // ----------------------------------------------------------------
  logic [4:0] busy_ff;
  logic [4:0] nxt_busy;
  logic [2:0] top_busy;
  always_comb begin
    top_busy = LVL_NONE;
    for (int l = 1; l <= 4; l++) begin
      if (busy_ff[l]) top_busy = 3'(l);
    end
  end

  logic blocked;
  assign blocked = best_lvl <= top_busy;

  // ----------------------------------------------------------------
  // Call sequencer
  // ----------------------------------------------------------------
  fvic_state_t state_ff;
  fvic_state_t nxt_state;
  logic [2:0] lvl_ff;
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      FVIC_IDLE: begin
        if (best_found && !blocked) nxt_state = FVIC_POLL;
      end
      FVIC_POLL: begin
        nxt_state = FVIC_CALL;
      end
      FVIC_CALL: begin
        if (vector_ack) nxt_state = FVIC_IDLE;
      end
      default: begin
        nxt_state = FVIC_IDLE;
      end
    endcase
  end

  // Winner frozen on poll so the vector stays stable until acknowledge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff <= FVIC_IDLE;
      slot_ff <= '0;
      lvl_ff <= LVL_NONE;
    end else begin
      state_ff <= nxt_state;
      if (state_ff == FVIC_IDLE) begin
        slot_ff <= best_slot;
        lvl_ff <= best_lvl;
      end
    end
  end

  // Nesting: acknowledge marks level, return frees the top one
  always_comb begin
    nxt_busy = busy_ff;
    if (service_return && top_busy != LVL_NONE) nxt_busy[top_busy] = 1'b0;
    if (call_take) nxt_busy[lvl_ff] = 1'b1;
  end
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) busy_ff <= '0;
    else busy_ff <= nxt_busy;
  end

  // Vector outputs come from flip-flops
  logic [15:0] vec_ff;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) vec_ff <= VEC_BASE;
    else if (state_ff == FVIC_POLL) vec_ff <= slot_vector(slot_ff);
  end

  assign vector_req = (state_ff == FVIC_CALL);
  assign vector_addr = vec_ff;
  assign vector_slot = slot_ff;
  assign active_level = top_busy;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_VEC_RANGE: assert property (@(posedge core_clk) disable iff (!rst_n)
    vector_req |-> vector_addr == slot_vector(slot_ff) && vector_addr <= VEC_LAST)
    else $error("vector address wrong");
  AST_NO_RSVD: assert property (@(posedge core_clk) disable iff (!rst_n)
    vector_req |-> slot_ff != SLOT_RSVD)
    else $error("reserved slot vectored");
  AST_GLOBAL_OFF: assert property (@(posedge core_clk) disable iff (!rst_n)
    !global_irq_enable |=> sample_ff == '0)
    else $error("request passed with global enable off");
  AST_POLL_LATENCY: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_ff == FVIC_IDLE && best_found && !blocked |=> state_ff == FVIC_POLL ##1 vector_req)
    else $error("call did not follow poll");
  AST_REQ_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    vector_req && !vector_ack |=> vector_req && $stable(vector_addr))
    else $error("request dropped before acknowledge");
  AST_NO_PREEMPT: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_ff == FVIC_IDLE && nxt_state == FVIC_POLL |-> best_lvl > top_busy)
    else $error("equal or lower level preempted");
  AST_TIE_LOW_SLOT: assert property (@(posedge core_clk) disable iff (!rst_n)
    best_found && sample_ff[0] && best_lvl == code_level({priority_high_bit[0],
    priority_low_bit[0]}) |-> best_slot == SLOT_EXT0)
    else $error("tie not won by lowest slot");
  AST_TMR_ACK_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    ack_t0 && !timer0_rollover && !flag_sw_set[2] |=> !tf0_ff)
    else $error("timer 0 flag not cleared on vectoring");
  AST_TMR_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    timer1_rollover |=> tf1_ff)
    else $error("timer 1 rollover lost");
  AST_SYS_ROUTE: assert property (@(posedge core_clk) disable iff (!rst_n)
    uart_tx_sysflag_route && uart_transmit_flag |-> raw_req[10])
    else $error("routed transmit flag missing");
  // Winner level must be the one its own code gives, whatever slot won
  AST_LVL_RANK: assert property (@(posedge core_clk) disable iff (!rst_n)
    best_found |-> best_lvl == code_level({priority_high_bit[best_slot],
    priority_low_bit[best_slot]}))
    else $error("winner level does not match its code");
  AST_EN_PASS: assert property (@(posedge core_clk) disable iff (!rst_n)
    global_irq_enable && (raw_req & slot_enable) != '0 |=> sample_ff != '0)
    else $error("enabled request not sampled");
  // Same-cycle return must not wipe the level that the call just marked
  AST_BUSY_MARK: assert property (@(posedge core_clk) disable iff (!rst_n)
    call_take |=> top_busy >= $past(lvl_ff))
    else $error("taken call level not marked busy");
  AST_CALL_ABOVE: assert property (@(posedge core_clk) disable iff (!rst_n)
    vector_req |-> lvl_ff > top_busy)
    else $error("call offered at or below the busy level");
  AST_SLOT_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n)
    vector_req && !vector_ack |=> $stable(vector_slot))
    else $error("slot changed before acknowledge");
  AST_TMR_SW_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    flag_sw_clr[2] && !timer0_rollover && !flag_sw_set[2] |=> !tf0_ff)
    else $error("software clear of timer 0 flag lost");

  CVR_CALL: cover property (@(posedge core_clk) disable iff (!rst_n) call_take);
  CVR_NEST: cover property (@(posedge core_clk) disable iff (!rst_n)
    call_take && top_busy != LVL_NONE);
  CVR_TIE: cover property (@(posedge core_clk) disable iff (!rst_n)
    $countones(sample_ff) > 1 && state_ff == FVIC_IDLE);
  CVR_SYS: cover property (@(posedge core_clk) disable iff (!rst_n)
    call_take && slot_ff == 4'ha);
endmodule : fvic_ctrl
`default_nettype wire

// File: fvic_ext_flag.sv
// External interrupt request flag with level or edge trigger
`timescale 1ns/10ps
`default_nettype none
module fvic_ext_flag
  import fvic_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pin_active,
  input wire logic trigger_type,
  input wire logic sw_set,
  input wire logic sw_clr,
  input wire logic vector_ack,
  output logic flag
);
  logic sync1_ff;
  logic sync2_ff;
  logic prev_ff;
  logic flag_ff;
  logic nxt_flag;
  logic edge_seen;

  // ----------------------------------------------------------------
  // Pin synchroniser, first stage read only by second stage
  // ----------------------------------------------------------------
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_ff <= 1'b0;
      sync2_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      sync1_ff <= pin_active;
      sync2_ff <= sync1_ff;
      prev_ff <= sync2_ff;
    end
  end

  // Edge mode latches; level mode mirrors the source
  assign edge_seen = sync2_ff & ~prev_ff;
  always_comb begin
    nxt_flag = flag_ff;
    if (trigger_type) begin
      if (vector_ack || sw_clr) nxt_flag = 1'b0;
      if (edge_seen || sw_set) nxt_flag = 1'b1;               // Set wins
    end else begin
      nxt_flag = sync2_ff | sw_set;
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) flag_ff <= 1'b0;
    else flag_ff <= nxt_flag;
  end
  assign flag = flag_ff;

  AST_EDGE_SET: assert property (@(posedge core_clk) disable iff (!rst_n)
    trigger_type && edge_seen |=> flag_ff)
    else $error("edge did not set flag");
  AST_EDGE_ACK_CLR: assert property (@(posedge core_clk) disable iff (!rst_n)
    trigger_type && vector_ack && !edge_seen && !sw_set |=> !flag_ff)
    else $error("edge flag not cleared on vectoring");
endmodule : fvic_ext_flag
`default_nettype wire

// File: fvic_pkg.sv
// Package of constants for the four-level vectored interrupt controller
package fvic_pkg;
  // ----------------------------------------------------------------
  // Slots and vectors
  // ----------------------------------------------------------------
  localparam int NUM_SLOTS = 14;
  localparam int SLOT_W = 4;
  localparam logic [3:0] SLOT_EXT0 = 4'h0;
  localparam logic [3:0] SLOT_TMR0 = 4'h1;
  localparam logic [3:0] SLOT_EXT1 = 4'h2;
  localparam logic [3:0] SLOT_TMR1 = 4'h3;
  localparam logic [3:0] SLOT_RSVD = 4'h6;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam logic [15:0] VEC_STEP = 16'h0008;
  localparam logic [15:0] VEC_LAST = 16'h006b;
  // Priority codes, two bits {high,low}
  localparam logic [1:0] PRIO_TOP = 2'h3;
  localparam logic [1:0] PRIO_LOW = 2'h0;
  // Level of the idle in-progress stack entry (below every code)
  localparam logic [2:0] LVL_NONE = 3'h0;
  // System-flag, PCA-module and ADC flag group widths
  localparam int SYS_W = 9;
  localparam int PCA_MOD_W = 4;
  localparam int ADC_W = 3;
  // Controller states
  typedef enum logic [1:0] {FVIC_IDLE, FVIC_POLL, FVIC_CALL} fvic_state_t;
endpackage : fvic_pkg
